// [tci_cfg_if.sv]
// Interface carrying latched configuration between modules
`timescale 1ns/1ps
`default_nettype none
interface tci_cfg_if;
	tci_pkg::tci_type_t sensor_type;
	logic               open_down;
	logic               open_test_off;
	logic               fahrenheit;
	logic               cjc_on;
	logic               valid;
	modport src (output sensor_type, output open_down, output open_test_off,
		output fahrenheit, output cjc_on, output valid);
	modport dst (input sensor_type, input open_down, input open_test_off,
		input fahrenheit, input cjc_on, input valid);
endinterface
`default_nettype wire

// [tci_cfg_latch.sv]
// Power-up capture of configuration switches
`timescale 1ns/1ps
`default_nettype none
module tci_cfg_latch (
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// Synchronised switch levels
	input  wire logic [7:0] sw_i,
	// Latched configuration
	tci_cfg_if.src          cfg
);
	tci_pkg::tci_state_t state;

	// Captured once after reset release, then frozen
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state             <= tci_pkg::ST_CAPTURE;
			cfg.valid         <= 1'b0;
			cfg.sensor_type   <= tci_pkg::TYPE_J;
			cfg.open_down     <= 1'b0;
			cfg.open_test_off <= 1'b0;
			cfg.fahrenheit    <= 1'b0;
			cfg.cjc_on        <= 1'b0;
		end else begin
			case (state)
				tci_pkg::ST_CAPTURE: begin
					cfg.sensor_type   <= tci_pkg::tci_type_t'(sw_i[2:0]);
					cfg.open_down     <= sw_i[4];
					cfg.open_test_off <= sw_i[5];
					cfg.fahrenheit    <= sw_i[6];
					cfg.cjc_on        <= sw_i[7];
					cfg.valid         <= 1'b1;
					state             <= tci_pkg::ST_RUN;
				end
				tci_pkg::ST_RUN: state <= tci_pkg::ST_RUN;
				default: state <= tci_pkg::ST_CAPTURE;
			endcase
		end
	end
endmodule
`default_nettype wire

// [tci_conv.sv]
// Per-channel correction, scale and open-wire substitution
`timescale 1ns/1ps
`default_nettype none
module tci_conv (
	// Configuration
	tci_cfg_if.dst            cfg,
	// Raw conversion and connector correction
	input  wire logic [17:0]  raw_i,
	input  wire logic [15:0]  cjc_i,
	// Result
	output logic      [15:0]  word_o,
	output logic              open_o
);
	wire        is_mv    = (cfg.sensor_type == tci_pkg::TYPE_MV);
	wire [17:0] mag      = raw_i[17] ? (~raw_i + 18'h0_0001) : raw_i;
	wire        open_det = (mag > tci_pkg::OPEN_LIM_RAW);
	wire [15:0] cjc_use  = (cfg.cjc_on && !is_mv) ? cjc_i : 16'h0000;
	wire [15:0] comp     = raw_i[15:0] + cjc_use;
	// F = C*9/5 + 32, kept in 0.1 degree units
	wire [19:0] c_ext    = {{4{comp[15]}}, comp};
	wire [19:0] f_mul    = (c_ext << 3) + c_ext;
	wire [19:0] f_div    = $signed(f_mul) / $signed(20'sd5);
	wire [15:0] f_val    = f_div[15:0] + tci_pkg::F_OFFSET;
	wire [15:0] scaled   = (cfg.fahrenheit && !is_mv) ? f_val : comp;
	wire [15:0] forced   = cfg.open_down ? tci_pkg::FORCE_DOWN : tci_pkg::FORCE_UP;
	assign word_o = open_det ? forced : scaled;
	assign open_o = open_det;
endmodule
`default_nettype wire

// [tci_pkg.sv]
// Package of constants and types for the thermocouple input block
// What this block does
// - A three-bit sensor type selector picks J, K, T, E, R, S, N or millivolt mode for all channels.
// - Switch settings are latched once after power-up and ignored until the next power cycle.
// - Open-wire direction 0 forces +3276.7 degrees and 1 forces -3276.8 degrees.
// - Open-wire enable 0 turns the 25 uA test current on and 1 turns it off.
// - The open-wire range check runs on every conversion regardless of the test current.
// - A channel whose input magnitude exceeds about 200 mV is declared open.
// - An open channel reports the forced value chosen by the direction selector.
// - Scale 0 reports Celsius and any Fahrenheit conversion is done inside the block.
// - When compensation is on, the connector temperature correction is added to each conversion before the Fahrenheit scaling.
// - Millivolt mode disables cold-junction compensation whatever its selector says.
// - Each reading is a 16-bit two's complement word in 0.1 degree units.
// - All four channels refresh every 405 ms only if the previous data was read, else hold.
package tci_pkg;
	localparam int          NUM_CH       = 4;
	localparam int          CLK_MHZ      = 250;
	localparam int          UPDATE_MS    = 405;
	localparam int          UPDATE_CYC   = UPDATE_MS * 1000 * CLK_MHZ;
	localparam logic [15:0] FORCE_UP     = 16'h7FFF;
	localparam logic [15:0] FORCE_DOWN   = 16'h8000;
	// 200 mV on the +/-80 mV scale of 27648 counts
	localparam logic [15:0] OPEN_LIMIT   = 16'hFFFF;
	localparam logic [17:0] OPEN_LIM_RAW = 18'h0_FC00;
	localparam logic [15:0] F_OFFSET     = 16'h0140;
	// Wishbone byte addresses
	localparam logic [5:0]  A_CONFIG     = 6'h00;
	localparam logic [5:0]  A_STATUS     = 6'h04;
	localparam logic [5:0]  A_MASK       = 6'h08;
	localparam logic [5:0]  A_CH0        = 6'h10;
	localparam logic [3:0]  MASK_RST     = 4'h0;
	typedef enum logic [2:0] {
		TYPE_J  = 3'b000,
		TYPE_K  = 3'b001,
		TYPE_T  = 3'b010,
		TYPE_E  = 3'b011,
		TYPE_R  = 3'b100,
		TYPE_S  = 3'b101,
		TYPE_N  = 3'b110,
		TYPE_MV = 3'b111
	} tci_type_t;
	typedef enum logic [1:0] {
		ST_CAPTURE = 2'b00,
		ST_RUN     = 2'b01
	} tci_state_t;
endpackage

// [tci_props.sv]
// Bus, interrupt and latch properties of the thermocouple input block
`timescale 1ns/1ps
`default_nettype none
module tci_props #(
	parameter int UPDATE_CYC = 50
) (
	// Clock and reset
	input wire logic        clk_i,
	input wire logic        rst_i,
	// Watched ports
	input wire logic        test_current_en_o,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        we_i,
	input wire logic [5:0]  adr_i,
	input wire logic [3:0]  sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic        ack_o,
	input wire logic        irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	chk_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
	chk_ack_take: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack late");
	chk_no_spur: assert property (!(cyc_i && stb_i) |=> !ack_o) else $error("ack unasked");
	chk_unmapped_zero: assert property (cyc_i && stb_i && !ack_o && !we_i && adr_i == 6'h3C
		|=> dat_o == 32'h0000_0000) else $error("unmapped read not zero");
	chk_cfg_hold: assert property (!rst_i [*8] |-> $stable(test_current_en_o))
		else $error("latched setting moved");
	chk_cfg_read: assert property (ack_o && !we_i && adr_i == tci_pkg::A_CONFIG
		|-> dat_o[5] == !test_current_en_o && dat_o[8]) else $error("config readback wrong");
	chk_mask_zero: assert property (ack_o && we_i && sel_i[0] && adr_i == tci_pkg::A_MASK
		&& dat_i[3:0] == 4'h0 |=> !irq_o) else $error("irq with mask cleared");
	chk_reset_quiet: assert property ($fell(rst_i) |-> !ack_o && !irq_o)
		else $error("outputs active after reset");
endmodule
`default_nettype wire

// [tci_sensor_model.sv]
// Behavioural sensors and connector correction source
`timescale 1ns/1ps
`default_nettype none
module tci_sensor_model (
	// Clock
	input  wire logic        clk_i,
	// Sensor samples and correction
	output logic      [71:0] raw_o,
	output logic      [15:0] cjc_o
);
	initial begin
		raw_o = 72'h00_0000_0000_0000_0000;
		cjc_o = 16'h0000;
	end
	// Broken wire shows as a large magnitude sample
	task automatic load(input logic [71:0] raw, input logic [15:0] cjc);
		@(posedge clk_i);
		raw_o <= raw;
		cjc_o <= cjc;
	endtask
endmodule
`default_nettype wire

// [tci_top.sv]
// Top of the four-channel thermocouple input block with Wishbone registers
`timescale 1ns/1ps
`default_nettype none
module tci_top #(
	parameter int UPDATE_CYC = tci_pkg::UPDATE_CYC
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Configuration switch pins
	input  wire logic [7:0]  sw_i,
	// Converter samples, one per channel, and connector correction
	input  wire logic [71:0] raw_i,
	input  wire logic [15:0] cjc_i,
	// Test current source control
	output logic             test_current_en_o,
	// Wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [5:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	// Interrupt
	output logic             irq_o
);
	logic [7:0]  sw_s1;
	logic [7:0]  sw_s2;
	logic [31:0] cnt;
	logic [15:0] chan  [tci_pkg::NUM_CH];
	logic [3:0]  open_st;
	logic        read_done;
	logic [3:0]  status;
	logic [3:0]  mask;
	logic [15:0] conv_w [tci_pkg::NUM_CH];
	logic [3:0]  conv_open;
	tci_cfg_if   cfg ();

	// Two-stage synchroniser for the switch pins
	always_ff @(posedge clk_i) begin
		sw_s1 <= sw_i;
		sw_s2 <= sw_s1;
	end

	tci_cfg_latch u_latch (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.sw_i  (sw_s2),
		.cfg   (cfg)
	);

	genvar g;
	generate
		for (g = 0; g < tci_pkg::NUM_CH; g++) begin : g_ch
			tci_conv u_conv (
				.cfg    (cfg),
				.raw_i  (raw_i[g*18 +: 18]),
				.cjc_i  (cjc_i),
				.word_o (conv_w[g]),
				.open_o (conv_open[g])
			);
		end
	endgenerate

	assign test_current_en_o = cfg.valid && !cfg.open_test_off;

	wire        tick     = (cnt == UPDATE_CYC - 1);
	wire        refresh  = tick && read_done && cfg.valid;
	wire        req      = cyc_i && stb_i && !ack_o;
	wire        wr       = req && we_i && sel_i[0];
	wire        rd       = req && !we_i;
	wire [1:0]  ch_idx   = adr_i[3:2];
	wire        is_ch    = (adr_i[5:4] == tci_pkg::A_CH0[5:4]);
	wire        rd_ch    = rd && is_ch;
	wire [3:0]  next_status = (status & ~((wr && adr_i == tci_pkg::A_STATUS) ? dat_i[3:0] : 4'h0))
		| (refresh ? conv_open : 4'h0);

	// Update period divider
	always_ff @(posedge clk_i) begin
		if (rst_i || tick)
			cnt <= 32'h0000_0000;
		else
			cnt <= cnt + 32'h0000_0001;
	end

	// Channel words held until read, then refreshed on the next period
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			read_done <= 1'b1;
			open_st   <= 4'h0;
			for (int i = 0; i < tci_pkg::NUM_CH; i++)
				chan[i] <= 16'h0000;
		end else begin
			if (refresh) begin
				for (int i = 0; i < tci_pkg::NUM_CH; i++)
					chan[i] <= conv_w[i];
				open_st   <= conv_open;
				read_done <= 1'b0;
			end else if (rd_ch) begin
				read_done <= 1'b1;
			end
		end
	end

	// Sticky open-wire events, set wins over clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			status <= 4'h0;
			mask   <= tci_pkg::MASK_RST;
		end else begin
			status <= next_status;
			if (wr && adr_i == tci_pkg::A_MASK)
				mask <= dat_i[3:0];
		end
	end

	wire [31:0] cfg_word = {23'h00_0000, cfg.valid, cfg.cjc_on, cfg.fahrenheit,
		cfg.open_test_off, cfg.open_down, 1'b0, cfg.sensor_type};
	wire [31:0] rd_mux =
		is_ch                          ? {16'h0000, chan[ch_idx]} :
		(adr_i == tci_pkg::A_CONFIG)   ? cfg_word :
		(adr_i == tci_pkg::A_STATUS)   ? {24'h00_0000, open_st, status} :
		(adr_i == tci_pkg::A_MASK)     ? {28'h000_0000, mask} :
		32'h0000_0000;

	// Single-wait-state Wishbone answer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end else begin
			ack_o <= req;
			dat_o <= rd ? rd_mux : 32'h0000_0000;
		end
	end

	assign irq_o = |(status & mask);
endmodule
`default_nettype wire

// [tci_top_tb.sv]
// Self-checking bench for the thermocouple input block
`timescale 1ns/1ps
`default_nettype none
module tci_top_tb;
	localparam int UPDATE_CYC = 50;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic [7:0]  sw_i  = 8'h00;
	logic        cyc_i = 1'b0;
	logic        stb_i = 1'b0;
	logic        we_i  = 1'b0;
	logic [5:0]  adr_i = 6'h00;
	logic [3:0]  sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0000_0000;
	logic [71:0] raw_i;
	logic [15:0] cjc_i;
	logic [31:0] dat_o;
	logic [31:0] rd;
	logic        ack_o;
	logic        irq_o;
	logic        test_current_en_o;
	int          err_count = 0;
	int          checks_done = 0;
	int          cycles = 0;
	always #2 clk_i = ~clk_i;
	tci_sensor_model sensor (.clk_i(clk_i), .raw_o(raw_i), .cjc_o(cjc_i));
	tci_top #(.UPDATE_CYC(UPDATE_CYC)) dut (.clk_i(clk_i), .rst_i(rst_i), .sw_i(sw_i),
		.raw_i(raw_i), .cjc_i(cjc_i), .test_current_en_o(test_current_en_o),
		.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
		.dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wb(input logic we, input logic [5:0] adr, input logic [31:0] wd);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= we;
		sel_i <= 4'hF;
		adr_i <= adr;
		dat_i <= wd;
		// Request held until ack is seen high at a rising edge
		do @(posedge clk_i); while (ack_o !== 1'b1);
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		sel_i <= 4'h0;
	endtask
	// Reset stands for a power cycle; reserved switch kept at 0
	task automatic power(input logic [7:0] sw, input logic [71:0] raw, input logic [15:0] cj);
		sensor.load(raw, cj);
		sw_i  <= sw;
		rst_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (UPDATE_CYC + 10) @(posedge clk_i);
	endtask
	task automatic t_config;
		for (int t = 0; t < 8; t++) begin
			power({5'h10, t[2:0]}, 72'h0, 16'h0000);
			wb(1'b0, tci_pkg::A_CONFIG, 32'h0000_0000);
			check(rd, {23'h0, 6'h30, t[2:0]} | 32'h0000_0100);
		end
		sw_i <= 8'h27;
		repeat (8) @(posedge clk_i);
		wb(1'b0, tci_pkg::A_CONFIG, 32'h0000_0000);
		check(rd, 32'h0000_0187);
		check({31'h0, test_current_en_o}, 32'h0000_0001);
		wb(1'b0, 6'h3C, 32'h0000_0000);
		check(rd, 32'h0000_0000);
		$display("test config done");
	endtask
	task automatic t_open;
		// Compensation on with a thermocouple type
		power(8'h81, {18'h2_0000, 36'h0, 18'h0_0064}, 16'h00A0);
		check({31'h0, test_current_en_o}, 32'h0000_0001);
		wb(1'b0, tci_pkg::A_CH0, 32'h0000_0000);
		check(rd, 32'h0000_0104);
		wb(1'b0, 6'h1C, 32'h0000_0000);
		check(rd, 32'h0000_7FFF);
		power(8'h30, {36'h0, 18'h1_0000, 18'h0}, 16'h0000);
		check({31'h0, test_current_en_o}, 32'h0000_0000);
		wb(1'b0, 6'h14, 32'h0000_0000);
		check(rd, 32'h0000_8000);
		repeat (UPDATE_CYC + 10) @(posedge clk_i);
		wb(1'b0, tci_pkg::A_STATUS, 32'h0000_0000);
		check(rd, 32'h0000_0022);
		wb(1'b1, tci_pkg::A_MASK, 32'h0000_0002);
		check({31'h0, irq_o}, 32'h0000_0001);
		wb(1'b1, tci_pkg::A_STATUS, 32'h0000_0002);
		check({31'h0, irq_o}, 32'h0000_0000);
		wb(1'b1, tci_pkg::A_MASK, 32'h0000_0000);
		$display("test open wire done");
	endtask
	task automatic t_scale;
		power(8'hC7, 72'h0_0064, 16'h00A0);
		wb(1'b0, tci_pkg::A_CH0, 32'h0000_0000);
		check(rd, 32'h0000_0064);
		power(8'h40, 72'h0_0064, 16'h00A0);
		sensor.load(72'h0_00C8, 16'h00A0);
		repeat (UPDATE_CYC + 10) @(posedge clk_i);
		wb(1'b0, tci_pkg::A_CH0, 32'h0000_0000);
		check(rd, 32'h0000_01F4);
		repeat (UPDATE_CYC + 10) @(posedge clk_i);
		wb(1'b0, tci_pkg::A_CH0, 32'h0000_0000);
		check(rd, 32'h0000_02A8);
		$display("test scale done");
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 4000) begin
			err_count++;
			close_out();
		end
	end
	initial begin
		t_config();
		t_open();
		t_scale();
		close_out();
	end
endmodule
bind tci_top tci_props #(.UPDATE_CYC(UPDATE_CYC)) u_props (.clk_i(clk_i), .rst_i(rst_i),
	.test_current_en_o(test_current_en_o), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
	.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o));
`default_nettype wire
